// ---- src/odcd_pkg.sv ----
// shared constants and types of the display command link
// assumes a single 200 MHz clock on both ends
package odcd_pkg;
	localparam int DW = 18;
	localparam int RAM_AW = 14;
	// opcodes
	localparam logic [7:0] OP_COL       = 8'h15;
	localparam logic [7:0] OP_ROW       = 8'h75;
	localparam logic [7:0] OP_WRAM      = 8'h5C;
	localparam logic [7:0] OP_RRAM      = 8'h5D;
	localparam logic [7:0] OP_REMAP     = 8'hA0;
	localparam logic [7:0] OP_START     = 8'hA1;
	localparam logic [7:0] OP_OFFS      = 8'hA2;
	localparam logic [5:0] OP_MODE_HI   = 6'h29;
	localparam logic [7:0] OP_FUNC      = 8'hAB;
	localparam logic [7:0] OP_SLEEP_ON  = 8'hAE;
	localparam logic [7:0] OP_SLEEP_OFF = 8'hAF;
	localparam logic [7:0] OP_PHASE     = 8'hB1;
	localparam logic [7:0] OP_CLK       = 8'hB3;
	localparam logic [7:0] OP_GPIO      = 8'hB5;
	localparam logic [7:0] OP_PRE2      = 8'hB6;
	localparam logic [7:0] OP_GRAY      = 8'hB8;
	localparam logic [7:0] OP_LOCK      = 8'hFD;
	localparam logic [7:0] OP_NONE      = 8'hE3;
	// lock parameter values
	localparam logic [7:0] LOCK_OPEN    = 8'h12;
	localparam logic [7:0] LOCK_ALL     = 8'h16;
	localparam logic [7:0] PROT_OPEN    = 8'hB1;
	localparam logic [7:0] PROT_CLOSE   = 8'hB0;
	// parameter counts and limits
	localparam logic [5:0] GRAY_LEN     = 6'd63;
	localparam logic [3:0] PH1_MIN      = 4'h2;
	localparam logic [3:0] PH2_MIN      = 4'h3;
	localparam logic [3:0] DIV_MAX      = 4'hA;
	localparam logic [3:0] SPI4_BITS    = 4'h8;
	localparam logic [3:0] SPI3_BITS    = 4'h9;
	// values after reset
	localparam logic [6:0] RST_END      = 7'h7F;
	localparam logic [6:0] RST_OFFS     = 7'h60;
	localparam logic [7:0] RST_REMAP    = 8'h20;
	localparam logic [7:0] RST_PHASE    = 8'h82;
	localparam logic [7:0] RST_CLK      = 8'hD1;
	localparam logic [3:0] RST_GPIO     = 4'hA;
	localparam logic [3:0] RST_PRE2     = 4'h8;
	localparam logic [7:0] RST_FUNC     = 8'h01;
	localparam logic [4:0] RST_CFG      = 5'h12;
	// host side timing and register offsets
	localparam logic [3:0] TICK_CYC     = 4'hF;
	localparam logic [3:0] REG_CMD      = 4'h0;
	localparam logic [3:0] REG_DATA     = 4'h4;
	localparam logic [3:0] REG_CFG      = 4'h8;

	typedef enum logic [1:0] {
		ODCD_ALL_OFF,
		ODCD_ALL_ON,
		ODCD_NORMAL,
		ODCD_INVERSE
	} odcd_disp_t;
endpackage

// ---- src/odcd_link_if.sv ----
// host bus pins between controller and display driver
// the data bus level is resolved here from both enables, pulled low
interface odcd_link_if;
	logic          reset_n_pin;
	logic          cs_n;
	logic          dc;
	logic          wr_n;
	logic          rd_n;
	logic [17:0]   host_d_out;
	logic          host_d_oe_n;
	logic [17:0]   dev_d_out;
	logic          dev_d_oe_n;
	logic [17:0]   d;

	assign d = !host_d_oe_n ? host_d_out : (!dev_d_oe_n ? dev_d_out : '0);

	modport dev_mp (input reset_n_pin, cs_n, dc, wr_n, rd_n, d,
		output dev_d_out, dev_d_oe_n);
	modport host_mp (output reset_n_pin, cs_n, dc, wr_n, rd_n, host_d_out,
		host_d_oe_n, input d);
endinterface

// ---- src/odcd_sync.sv ----
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to i_clock
module odcd_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         i_clock,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_ff <= RST;
			sync_ff <= RST;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule

// ---- src/odcd_device.sv ----
// display driver end: pin receiver, command decoder, settings, display ram
// assumes the link pins are asynchronous and pass a synchroniser first
// Functional notes
// - dc pin low means opcode, high data; 3-wire SPI takes it from the first of nine bits instead
// - reset pin low restores all settings
// - transfers ignored unless chip select low
// - 6800: rw high reads, enable strobes
// - 8080: write strobe rising edge captures write
// - 8080: read strobe low drives data bus
// - four-bit code selects SPI or parallel port
// - low code bits strapped, high from 0xAB
// - 0x15/0x75 set column and row window
// - write/read ram opcodes stream pixel data
// - remap parameter sets scan and order flags
// - remap bits 7:6 select colour depth
// - 0xA1 sets display start line
// - 0xA2 sets row offset, reset 0x60
// - 0xA4..0xA7 select display mode
// - 0xAE sleeps display, 0xAF wakes
// - 0xB1 sets phase lengths, invalid codes rejected
// - protected commands rejected while locked
// - 0xB3 sets divider and oscillator level
// - 0xB5 sets two gpio pin modes
// - 0xB6 sets second precharge, zero invalid
// - 0xB8 loads 63 gray table bytes
// - 0xFD parameter locks or unlocks interface
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
module odcd_device
	import odcd_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic [1:0]  i_port_strap,
	odcd_link_if.dev_mp      link,
	output logic [6:0]       o_col_start,
	output logic [6:0]       o_col_end,
	output logic [6:0]       o_row_start,
	output logic [6:0]       o_row_end,
	output logic [7:0]       o_remap,
	output logic [6:0]       o_start_line,
	output logic [6:0]       o_row_offset,
	output odcd_disp_t       o_disp_mode,
	output logic             o_sleep,
	output logic [7:0]       o_phase,
	output logic [7:0]       o_clock_setting,
	output logic [3:0]       o_gpio_mode,
	output logic [3:0]       o_precharge2,
	output logic [7:0]       o_function,
	output logic             o_cmd_locked,
	output logic             o_prot_locked,
	output logic [503:0]     o_gray_table
);
	typedef struct packed {
		logic [2:0]   prv;
		logic [3:0]   bitn;
		logic [8:0]   shf;
		logic [7:0]   op;
		logic [5:0]   pcnt;
		logic [6:0]   p0;
		logic         wram;
		logic         rram;
		logic [6:0]   col;
		logic [6:0]   row;
		logic [6:0]   cst;
		logic [6:0]   cend;
		logic [6:0]   rst;
		logic [6:0]   rend;
		logic [7:0]   remap;
		logic [6:0]   sline;
		logic [6:0]   offs;
		odcd_disp_t   mode;
		logic         sleep;
		logic [7:0]   phase;
		logic [7:0]   clk;
		logic [3:0]   gpio;
		logic [3:0]   pre2;
		logic [7:0]   func;
		logic         locked;
		logic         prot;
		logic [503:0] gsh;
		logic [503:0] gray;
		logic [17:0]  dout;
		logic         oe_n;
	} odcd_dev_t;

	localparam odcd_dev_t DEV_RST = '{prv: 3'h6, cend: RST_END, rend: RST_END,
		remap: RST_REMAP, offs: RST_OFFS, mode: ODCD_NORMAL, phase: RST_PHASE,
		clk: RST_CLK, gpio: RST_GPIO, pre2: RST_PRE2, func: RST_FUNC,
		prot: 1'b1, oe_n: 1'b1, default: '0};

	odcd_dev_t     q_ff;
	odcd_dev_t     nxt_q;
	logic [24:0]   s_pins;
	logic          s_rst_n, s_cs_n, s_dc, s_wr, s_rd;
	logic [1:0]    s_strap;
	logic [17:0]   s_d;
	logic          spi, three, m6800, rx, rx_dc, rd_req, drive, last;
	logic [17:0]   rx_w, wmask;
	logic [7:0]    b;
	logic [5:0]    need;
	logic [8:0]    shf_nx;
	logic [3:0]    bit_nx;
	logic          ram_we;
	logic [17:0]   ram_mem [0:(1<<RAM_AW)-1];

	odcd_sync #(.W(25), .RST({2'h0, 5'h1F, 18'h0})) u_sync (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async ({i_port_strap, link.reset_n_pin, link.cs_n, link.dc,
			link.wr_n, link.rd_n, link.d}),
		.o_sync  (s_pins)
	);
	assign {s_strap, s_rst_n, s_cs_n, s_dc, s_wr, s_rd, s_d} = s_pins;

	function automatic logic [5:0] param_need(input logic [7:0] op);
		case (op)
			OP_COL, OP_ROW: param_need = 6'd2;
			OP_GRAY: param_need = GRAY_LEN;
			OP_REMAP, OP_START, OP_OFFS, OP_FUNC, OP_PHASE, OP_CLK, OP_GPIO,
			OP_PRE2, OP_LOCK: param_need = 6'd1;
			default: param_need = 6'd0;
		endcase
	endfunction

	function automatic logic [13:0] step(input odcd_dev_t s);
		logic [6:0] nr;
		logic [6:0] nc;
		nr = s.row;
		nc = s.col;
		if (!s.remap[0]) begin
			nc = (s.col == s.cend) ? s.cst : s.col + 7'd1;
			if (s.col == s.cend)
				nr = (s.row == s.rend) ? s.rst : s.row + 7'd1;
		end else begin
			nr = (s.row == s.rend) ? s.rst : s.row + 7'd1;
			if (s.row == s.rend)
				nc = (s.col == s.cend) ? s.cst : s.col + 7'd1;
		end
		step = {nr, nc};
	endfunction

	always_comb begin
		nxt_q = q_ff;
		rx = 1'b0;
		rx_dc = 1'b0;
		rx_w = '0;
		wmask = {{2{&q_ff.func[7:6]}}, {8{q_ff.func[6]}}, 8'hFF};
		rd_req = 1'b0;
		drive = 1'b0;
		ram_we = 1'b0;
		shf_nx = {q_ff.shf[7:0], s_d[1]};
		bit_nx = q_ff.bitn + 4'h1;
		spi = !s_strap[1];
		three = s_strap[0];
		m6800 = s_strap[0];
		nxt_q.prv = {s_wr, s_rd, s_d[0]};
		if (s_cs_n) begin
			nxt_q.bitn = '0;
		end else if (spi) begin
			if (s_d[0] && !q_ff.prv[0]) begin
				nxt_q.shf = shf_nx;
				nxt_q.bitn = bit_nx;
				if (bit_nx == (three ? SPI3_BITS : SPI4_BITS)) begin
					rx = 1'b1;
					rx_dc = three ? shf_nx[8] : s_dc;
					rx_w = {10'h0, shf_nx[7:0]};
					nxt_q.bitn = '0;
				end
			end
		end else if (m6800) begin
			rx = !s_rd && q_ff.prv[1] && !s_wr;
			rd_req = s_rd && !q_ff.prv[1] && s_wr;
			drive = s_rd && s_wr;
			rx_dc = s_dc;
			rx_w = s_d & wmask;
		end else begin
			rx = s_wr && !q_ff.prv[2];
			rd_req = !s_rd && q_ff.prv[1];
			drive = !s_rd;
			rx_dc = s_dc;
			rx_w = s_d & wmask;
		end
		nxt_q.oe_n = !(drive && !s_cs_n && !spi);
		b = rx_w[7:0];
		need = param_need(q_ff.op);
		last = (q_ff.pcnt == need - 6'd1);
		if (rx && !rx_dc) begin
			nxt_q.op = (q_ff.locked && b != OP_LOCK) ? OP_NONE : b;
			nxt_q.pcnt = '0;
			nxt_q.wram = 1'b0;
			nxt_q.rram = 1'b0;
			if (!q_ff.locked) begin
				if (b[7:2] == OP_MODE_HI)
					nxt_q.mode = odcd_disp_t'(b[1:0]);
				if (b == OP_SLEEP_ON)
					nxt_q.sleep = 1'b1;
				if (b == OP_SLEEP_OFF)
					nxt_q.sleep = 1'b0;
				if (b == OP_WRAM || b == OP_RRAM) begin
					nxt_q.wram = (b == OP_WRAM);
					nxt_q.rram = (b == OP_RRAM);
					nxt_q.col = q_ff.cst;
					nxt_q.row = q_ff.rst;
				end
			end
		end else if (rx && q_ff.wram) begin
			ram_we = 1'b1;
			{nxt_q.row, nxt_q.col} = step(q_ff);
		end else if (rx && q_ff.pcnt < need) begin
			nxt_q.pcnt = q_ff.pcnt + 6'd1;
			nxt_q.p0 = b[6:0];
			if (q_ff.op == OP_GRAY)
				nxt_q.gsh[{q_ff.pcnt, 3'b000} +: 8] = b;
			if (last) begin
				unique case (q_ff.op)
					OP_COL: begin
						nxt_q.cst = q_ff.p0;
						nxt_q.cend = b[6:0];
						nxt_q.col = q_ff.p0;
					end
					OP_ROW: begin
						nxt_q.rst = q_ff.p0;
						nxt_q.rend = b[6:0];
						nxt_q.row = q_ff.p0;
					end
					OP_REMAP: nxt_q.remap = b;
					OP_START: nxt_q.sline = b[6:0];
					OP_OFFS: if (!q_ff.prot)
						nxt_q.offs = b[6:0];
					OP_FUNC: nxt_q.func = {b[7:6], 5'h0, b[0]};
					OP_PHASE: if (!q_ff.prot && b[3:0] >= PH1_MIN &&
							b[7:4] >= PH2_MIN)
						nxt_q.phase = b;
					OP_CLK: if (!q_ff.prot && b[3:0] <= DIV_MAX)
						nxt_q.clk = b;
					OP_GPIO: nxt_q.gpio = b[3:0];
					OP_PRE2: if (b[3:0] != 4'h0)
						nxt_q.pre2 = b[3:0];
					OP_GRAY: nxt_q.gray =
						{b, q_ff.gsh[495:0]};
					OP_LOCK: begin
						if (b == LOCK_OPEN)
							nxt_q.locked = 1'b0;
						if (b == LOCK_ALL)
							nxt_q.locked = 1'b1;
						if (b == PROT_OPEN)
							nxt_q.prot = 1'b0;
						if (b == PROT_CLOSE)
							nxt_q.prot = 1'b1;
					end
					default: ;
				endcase
			end
		end
		if (rd_req) begin
			nxt_q.dout = q_ff.rram ? ram_mem[{q_ff.row, q_ff.col}] : '0;
			if (q_ff.rram)
				{nxt_q.row, nxt_q.col} = step(q_ff);
		end
		if (!s_rst_n) begin
			nxt_q = DEV_RST;
			ram_we = 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			q_ff <= DEV_RST;
		else
			q_ff <= nxt_q;
	end

	always_ff @(posedge i_clock) begin
		if (ram_we)
			ram_mem[{q_ff.row, q_ff.col}] <= rx_w;
	end

	assign link.dev_d_out = q_ff.dout;
	assign link.dev_d_oe_n = q_ff.oe_n;
	assign o_col_start = q_ff.cst;
	assign o_col_end = q_ff.cend;
	assign o_row_start = q_ff.rst;
	assign o_row_end = q_ff.rend;
	assign o_remap = q_ff.remap;
	assign o_start_line = q_ff.sline;
	assign o_row_offset = q_ff.offs;
	assign o_disp_mode = q_ff.mode;
	assign o_sleep = q_ff.sleep;
	assign o_phase = q_ff.phase;
	assign o_clock_setting = q_ff.clk;
	assign o_gpio_mode = q_ff.gpio;
	assign o_precharge2 = q_ff.pre2;
	assign o_function = q_ff.func;
	assign o_cmd_locked = q_ff.locked;
	assign o_prot_locked = q_ff.prot;
	assign o_gray_table = q_ff.gray;
endmodule

// ---- src/odcd_host.sv ----
// controller end: avalon-mm slave that drives the display host bus
// assumes software sets the port code to match the driver's straps
module odcd_host
	import odcd_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	odcd_link_if.host_mp     link
);
	typedef enum logic [2:0] {
		H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_ACK
	} odcd_hst_t;

	typedef struct packed {
		odcd_hst_t   st;
		logic [3:0]  tcnt;
		logic [3:0]  bitn;
		logic [8:0]  shf;
		logic [4:0]  cfg;
		logic        rd;
		logic        cs_n;
		logic        dc;
		logic        wr_n;
		logic        rd_n;
		logic [17:0] dout;
		logic        oe_n;
		logic        wait_r;
		logic [31:0] rdata;
	} odcd_host_t;

	localparam odcd_host_t HOST_RST = '{st: H_IDLE, cfg: RST_CFG, cs_n: 1'b1,
		wr_n: 1'b1, rd_n: 1'b1, oe_n: 1'b1, wait_r: 1'b1, default: '0};

	odcd_host_t  q_ff;
	odcd_host_t  nxt_q;
	logic [17:0] s_d;
	logic        tick, spi, three, m6800;
	logic [8:0]  shf_nx;

	odcd_sync #(.W(18)) u_sync (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async (link.d),
		.o_sync  (s_d)
	);

	always_comb begin
		nxt_q = q_ff;
		nxt_q.wait_r = 1'b1;
		tick = (q_ff.tcnt == TICK_CYC);
		nxt_q.tcnt = tick ? 4'h0 : q_ff.tcnt + 4'h1;
		spi = !q_ff.cfg[1];
		three = q_ff.cfg[0];
		m6800 = q_ff.cfg[0];
		shf_nx = {q_ff.shf[7:0], 1'b0};
		unique case (q_ff.st)
			H_IDLE: begin
				nxt_q.cs_n = 1'b1;
				nxt_q.oe_n = 1'b1;
				// 6800 keeps the direction level between transfers
				nxt_q.wr_n = !spi && (!m6800 || q_ff.wr_n);
				nxt_q.rd_n = !spi && !m6800;
				if (i_avs_write && i_avs_address == REG_CFG) begin
					nxt_q.cfg = i_avs_writedata[4:0];
					nxt_q.st = H_ACK;
					nxt_q.wait_r = 1'b0;
				end else if (i_avs_read && i_avs_address == REG_CFG) begin
					nxt_q.rdata = {27'h0, q_ff.cfg};
					nxt_q.st = H_ACK;
					nxt_q.wait_r = 1'b0;
				end else if ((i_avs_write && (i_avs_address == REG_CMD ||
						i_avs_address == REG_DATA)) || (i_avs_read && !spi &&
						i_avs_address == REG_DATA)) begin
					nxt_q.rd = i_avs_read;
					nxt_q.dc = (i_avs_address == REG_DATA);
					nxt_q.cs_n = 1'b0;
					nxt_q.wr_n = spi ? 1'b0 : !(m6800 && i_avs_read) ? 1'b0
						: 1'b1;
					if (!m6800 && !spi)
						nxt_q.wr_n = 1'b1;
					nxt_q.oe_n = i_avs_read;
					nxt_q.bitn = 4'h0;
					// full tick of setup before the first strobe edge
					nxt_q.tcnt = 4'h0;
					nxt_q.shf = three ? {i_avs_address == REG_DATA,
						i_avs_writedata[7:0]} : {i_avs_writedata[7:0], 1'b0};
					nxt_q.dout = spi ? {16'h0, nxt_q.shf[8], 1'b0}
						: i_avs_writedata[17:0];
					nxt_q.rdata = '0;
					nxt_q.st = H_SETUP;
				end else if (i_avs_read || i_avs_write) begin
					nxt_q.rdata = '0;
					nxt_q.st = H_ACK;
					nxt_q.wait_r = 1'b0;
				end
			end
			H_SETUP: if (tick) begin
				if (spi)
					nxt_q.dout[0] = 1'b1;
				else if (m6800)
					nxt_q.rd_n = 1'b1;
				else if (q_ff.rd)
					nxt_q.rd_n = 1'b0;
				else
					nxt_q.wr_n = 1'b0;
				nxt_q.st = H_STROBE;
			end
			H_STROBE: if (tick) begin
				if (spi) begin
					nxt_q.dout[0] = 1'b0;
					nxt_q.shf = shf_nx;
					nxt_q.bitn = q_ff.bitn + 4'h1;
					nxt_q.dout[1] = shf_nx[8];
					nxt_q.st = (q_ff.bitn + 4'h1 ==
						(three ? SPI3_BITS : SPI4_BITS)) ? H_HOLD : H_SETUP;
				end else begin
					nxt_q.rd_n = !m6800;
					nxt_q.wr_n = 1'b1;
					if (m6800)
						nxt_q.wr_n = q_ff.rd;
					if (q_ff.rd)
						nxt_q.rdata = {14'h0, s_d};
					nxt_q.st = H_HOLD;
				end
			end
			H_HOLD: if (tick) begin
				nxt_q.cs_n = 1'b1;
				nxt_q.oe_n = 1'b1;
				nxt_q.st = H_ACK;
				nxt_q.wait_r = 1'b0;
			end
			H_ACK: nxt_q.st = H_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			q_ff <= HOST_RST;
		else
			q_ff <= nxt_q;
	end

	assign o_avs_readdata = q_ff.rdata;
	assign o_avs_waitrequest = q_ff.wait_r;
	assign link.reset_n_pin = q_ff.cfg[4];
	assign link.cs_n = q_ff.cs_n;
	assign link.dc = q_ff.dc;
	assign link.wr_n = q_ff.wr_n;
	assign link.rd_n = q_ff.rd_n;
	assign link.host_d_out = q_ff.dout;
	assign link.host_d_oe_n = q_ff.oe_n;
endmodule

// ---- verification/odcd_link_properties.sv ----
// checker: concurrent properties on the display host link pins
// assumes the link signals and the controller clock and reset
module odcd_link_properties (
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic        reset_n_pin,
	input  wire logic        cs_n,
	input  wire logic        dc,
	input  wire logic        wr_n,
	input  wire logic        rd_n,
	input  wire logic [17:0] host_d_out,
	input  wire logic        host_d_oe_n,
	input  wire logic        dev_d_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wstb;
	assign wstb = !cs_n && !wr_n && rd_n;
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);
	property p_no_clash;
		!(!host_d_oe_n && !dev_d_oe_n);
	endproperty
	property p_dev_sel;
		!dev_d_oe_n |-> !cs_n;
	endproperty
	property p_wr_len;
		$changed(wr_n) |=> $stable(wr_n)[*8];
	endproperty
	property p_rd_len;
		$changed(rd_n) |=> $stable(rd_n)[*8];
	endproperty
	property p_dc_hold;
		!cs_n && !$past(cs_n) |-> $stable(dc);
	endproperty
	property p_wdata;
		wstb && $past(wstb) |-> $stable(host_d_out);
	endproperty
	property p_frame;
		$fell(cs_n) |-> ##[1:400] $rose(cs_n);
	endproperty
	property p_wr_drive;
		!cs_n && !wr_n |-> !host_d_oe_n;
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive the data bus");
	a_dev_sel: assert property (p_dev_sel)
		else $error("device drives while not selected");
	a_wr_len: assert property (p_wr_len)
		else $error("write strobe level too short");
	a_rd_len: assert property (p_rd_len)
		else $error("read strobe level too short");
	a_dc_hold: assert property (p_dc_hold)
		else $error("dc changed inside a transfer");
	a_wdata: assert property (p_wdata)
		else $error("write data moved during strobe");
	a_frame: assert property (p_frame)
		else $error("chip select held too long");
	a_wr_drive: assert property (p_wr_drive)
		else $error("write without host driving the bus");
	c_write: cover property ($rose(wr_n) && !cs_n);
	c_read: cover property (!dev_d_oe_n);
	c_pin_reset: cover property ($fell(reset_n_pin));
endmodule

// ---- verification/test_oled_driver_command_decoder.sv ----
// testbench: controller and display driver joined over the link
// assumes odcd_pkg, odcd_link_if and both design ends are compiled
module test_oled_driver_command_decoder
	import odcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          i_clock;
	logic          i_nrst;
	logic [1:0]    strap;
	logic [3:0]    avs_address;
	logic          avs_read;
	logic          avs_write;
	logic [31:0]   avs_writedata;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic [31:0]   rdata;
	logic [6:0]    col_s, col_e, row_s, row_e, sline, roff;
	logic [7:0]    remap, phase, clk_set, func;
	logic [3:0]    gpio, pre2;
	logic          sleep, c_lock, p_lock;
	odcd_disp_t    mode;
	logic [503:0]  gray;
	int            n_errors = 0;
	int            checks_done = 0;
	int            cycles = 0;

	odcd_link_if odcd_link_if_inst ();
	odcd_host odcd_host_inst (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_avs_address(avs_address), .i_avs_read(avs_read),
		.i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.link(odcd_link_if_inst));
	odcd_device odcd_device_inst (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_port_strap(strap), .link(odcd_link_if_inst),
		.o_col_start(col_s), .o_col_end(col_e), .o_row_start(row_s),
		.o_row_end(row_e), .o_remap(remap), .o_start_line(sline),
		.o_row_offset(roff), .o_disp_mode(mode), .o_sleep(sleep),
		.o_phase(phase), .o_clock_setting(clk_set), .o_gpio_mode(gpio),
		.o_precharge2(pre2), .o_function(func), .o_cmd_locked(c_lock),
		.o_prot_locked(p_lock), .o_gray_table(gray));
	odcd_link_properties odcd_link_properties_inst (.i_clock(i_clock),
		.i_nrst(i_nrst), .reset_n_pin(odcd_link_if_inst.reset_n_pin),
		.cs_n(odcd_link_if_inst.cs_n), .dc(odcd_link_if_inst.dc),
		.wr_n(odcd_link_if_inst.wr_n), .rd_n(odcd_link_if_inst.rd_n),
		.host_d_out(odcd_link_if_inst.host_d_out),
		.host_d_oe_n(odcd_link_if_inst.host_d_oe_n),
		.dev_d_oe_n(odcd_link_if_inst.dev_d_oe_n));

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic av(input logic [3:0] a, input logic rd,
		input logic [31:0] v);
		@(posedge i_clock);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= v;
		do @(posedge i_clock); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wc(input logic [7:0] op);
		av(REG_CMD, 1'b0, {24'h0, op});
	endtask

	task automatic wd(input logic [17:0] v);
		av(REG_DATA, 1'b0, {14'h0, v});
	endtask

	task automatic set(input logic [7:0] op, input logic [7:0] p);
		wc(op);
		wd({10'h0, p});
	endtask

	task automatic t_reset;
		chk(col_s === 7'h00 && col_e === 7'h7F, "column window");
		chk(row_s === 7'h00 && row_e === 7'h7F, "row window");
		chk(remap === 8'h20 && sline === 7'h00, "remap or start");
		chk(roff === 7'h60 && mode === ODCD_NORMAL, "offset or mode");
		chk(sleep === 1'b0 && phase === 8'h82, "sleep or phase");
		chk(clk_set === 8'hD1 && gpio === 4'hA, "clock or gpio");
		chk(pre2 === 4'h8 && func === 8'h01, "precharge or func");
		chk(c_lock === 1'b0 && p_lock === 1'b1, "lock state");
		chk(gray === '0, "gray table");
		av(REG_CFG, 1'b1, '0);
		chk(rdata[4:0] === 5'h12, "config reset");
		av(4'hC, 1'b1, '0);
		chk(rdata === 32'h0, "unmapped read");
	endtask

	task automatic t_protect;
		set(8'hA2, 8'h11);
		chk(roff === 7'h60, "offset while protected");
		set(8'hFD, 8'hB1);
		set(8'hA2, 8'h11);
		chk(roff === 7'h11 && p_lock === 1'b0, "offset");
		set(8'hB1, 8'h31);
		set(8'hB1, 8'h23);
		chk(phase === 8'h82, "invalid phase kept");
		set(8'hB1, 8'h32);
		chk(phase === 8'h32, "phase");
		set(8'hB3, 8'h0B);
		chk(clk_set === 8'hD1, "invalid divider kept");
		set(8'hB3, 8'h4A);
		chk(clk_set === 8'h4A, "divider");
		set(8'hB6, 8'h00);
		chk(pre2 === 4'h8, "invalid precharge kept");
		set(8'hB6, 8'h0F);
		chk(pre2 === 4'hF, "precharge");
		set(8'hB5, 8'h0D);
		chk(gpio === 4'hD, "gpio modes");
		set(8'hFD, 8'hB0);
		set(8'hA2, 8'h22);
		chk(roff === 7'h11 && p_lock === 1'b1, "protection closed");
		set(8'hFD, 8'hB1);
	endtask

	task automatic t_window;
		set(8'h15, 8'h05);
		wd(18'h7A);
		chk(col_s === 7'h05 && col_e === 7'h7A, "column set");
		set(8'h75, 8'h03);
		chk(row_s === 7'h00, "row applied early");
		set(8'hA1, 8'h33);
		chk(sline === 7'h33 && row_s === 7'h00, "aborted row");
		set(8'h75, 8'h03);
		wd(18'h10);
		chk(row_s === 7'h03 && row_e === 7'h10, "row set");
	endtask

	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			wc(8'(8'hA4 + i));
			chk(mode === odcd_disp_t'(i), "display mode");
		end
		wc(8'hAE);
		chk(sleep === 1'b1, "sleep on");
		wc(8'hAF);
		chk(sleep === 1'b0, "sleep off");
		set(8'hA0, 8'hD7);
		chk(remap === 8'hD7, "remap");
	endtask

	task automatic t_ram;
		set(8'h15, 8'h02);
		wd(18'h03);
		set(8'h75, 8'h04);
		wd(18'h04);
		wc(8'h5C);
		wd(18'hA5);
		wd(18'h3FF3C);
		wd(18'h5A);
		wc(8'h5D);
		av(REG_DATA, 1'b1, '0);
		chk(rdata[7:0] === 8'h5A, "ram wrapped word");
		av(REG_DATA, 1'b1, '0);
		chk(rdata[17:0] === 18'h0003C, "ram second word");
	endtask

	task automatic t_gray;
		logic [503:0] g;
		g = '0;
		wc(8'hB8);
		for (int k = 0; k < 63; k++) begin
			g[8*k +: 8] = 8'(2 * k + 1);
			if (k == 62) begin
				chk(gray === '0, "table before last byte");
			end
			wd(18'(2 * k + 1));
		end
		chk(gray === g, "gray table");
		wd(18'hFF);
		chk(gray === g, "extra byte ignored");
	endtask

	task automatic t_lock;
		set(8'hFD, 8'h16);
		chk(c_lock === 1'b1, "lock all");
		set(8'hA1, 8'h05);
		chk(sline === 7'h33, "command while locked");
		set(8'hFD, 8'h12);
		set(8'hA1, 8'h05);
		chk(c_lock === 1'b0 && sline === 7'h05, "unlocked");
	endtask

	task automatic t_ports;
		logic [1:0] st [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
		logic [4:0] cf [4] = '{5'h13, 5'h10, 5'h11, 5'h12};
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clock);
			strap <= st[i];
			av(REG_CFG, 1'b0, {27'h0, cf[i]});
			set(8'hA1, 8'(8'h40 + i));
			chk(sline === 7'(7'h40 + i), "port mode");
		end
		set(8'hAB, 8'h41);
		chk(func === 8'h41, "function select");
		av(REG_CFG, 1'b0, 32'h16);
		set(8'h15, 8'h00);
		wd(18'h0);
		set(8'h75, 8'h00);
		wd(18'h0);
		wc(8'h5C);
		wd(18'h3BEEF);
		wc(8'h5D);
		av(REG_DATA, 1'b1, '0);
		chk(rdata[17:0] === 18'h0BEEF, "wide ram word");
		set(8'hAB, 8'h01);
		av(REG_CFG, 1'b0, 32'h12);
	endtask

	task automatic t_pinrst;
		av(REG_CFG, 1'b0, 32'h02);
		repeat (8) @(posedge i_clock);
		chk(sline === 7'h00 && roff === 7'h60, "pin reset");
		chk(p_lock === 1'b1 && pre2 === 4'h8, "pin reset locks");
		av(REG_CFG, 1'b0, 32'h12);
		av(REG_CFG, 1'b1, '0);
		chk(rdata[4:0] === 5'h12, "config readback");
	endtask

	initial begin
		i_nrst = 1'b0;
		strap = 2'b10;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		repeat (16) @(posedge i_clock);
		i_nrst <= 1'b1;
		t_reset();
		t_protect();
		t_window();
		t_modes();
		t_ram();
		t_gray();
		t_lock();
		t_ports();
		t_pinrst();
		wrap_up();
	end
endmodule
